// *** logic/cmr_pkg.sv ***
package cmr_pkg;

  // ==========================================================================
  // Packet words and header layout
  // ==========================================================================
  localparam logic [31:0] BUS_SYNC_WORD     = 32'h000000bb;
  localparam logic [31:0] BUS_DETECT_WORD   = 32'h11220044;
  localparam logic [31:0] SYNC_WORD         = 32'haa995566;
  localparam logic [31:0] NO_OPERATION_WORD = 32'h20000000;
  localparam logic [2:0]  PKT_TYPE1         = 3'h1;
  localparam logic [2:0]  PKT_TYPE2         = 3'h2;
  localparam logic [1:0]  OP_READ           = 2'h1;
  localparam logic [1:0]  OP_WRITE          = 2'h2;
  localparam logic [4:0]  ADDR_FRAME_ADDRESS_REG  = 5'h01;
  localparam logic [4:0]  ADDR_FRAME_DATA_OUT_REG = 5'h03;
  localparam logic [4:0]  ADDR_COMMAND_REG        = 5'h04;

  typedef struct packed {
    logic [2:0]  ptype;
    logic [1:0]  op;
    logic [8:0]  rsv_hi;
    logic [4:0]  addr;
    logic [1:0]  rsv_lo;
    logic [10:0] count;
  } cmr_hdr_s;

  // ==========================================================================
  // Command codes
  // ==========================================================================
  localparam logic [4:0] READ_CONFIG_CMD   = 5'h04;
  localparam logic [4:0] START_CMD         = 5'h05;
  localparam logic [4:0] CRC_RESET_CMD     = 5'h07;
  localparam logic [4:0] SHUTDOWN_CMD      = 5'h0b;
  localparam logic [4:0] DESYNCHRONIZE_CMD = 5'h0d;

  // ==========================================================================
  // Readback shape and timing
  // ==========================================================================
  localparam logic [4:0]  PIPE_WORDS_EARLY = 5'h0a;
  localparam logic [4:0]  PIPE_WORDS_LATER = 5'h19;
  localparam logic [15:0] WORDS_PER_FRAME  = 16'h0064;
  localparam logic [1:0]  READ_LATENCY     = 2'h2;
  localparam logic [7:0]  STARTUP_CYCLES   = 8'h10;

  // ==========================================================================
  // JTAG instructions, link states and TAP states
  // ==========================================================================
  localparam logic [5:0] IR_CFG_IN  = 6'h05;
  localparam logic [5:0] IR_CFG_OUT = 6'h04;
  localparam logic [5:0] IR_RESET   = 6'h3f;
  localparam logic [5:0] IR_CAPTURE = 6'h01;
  localparam logic [4:0] LAST_BIT   = 5'h1f;

  typedef enum logic [5:0] {
    LK_HUNT = 6'h01, LK_WIDTH = 6'h02, LK_SYNC = 6'h04,
    LK_HDR  = 6'h08, LK_WDATA = 6'h10, LK_T2   = 6'h20
  } cmr_link_e;

  typedef enum logic [15:0] {
    TP_TLR   = 16'h0001, TP_RTI   = 16'h0002, TP_SELDR = 16'h0004, TP_CAPDR = 16'h0008,
    TP_SHDR  = 16'h0010, TP_EX1DR = 16'h0020, TP_PADR  = 16'h0040, TP_EX2DR = 16'h0080,
    TP_UPDR  = 16'h0100, TP_SELIR = 16'h0200, TP_CAPIR = 16'h0400, TP_SHIR  = 16'h0800,
    TP_EX1IR = 16'h1000, TP_PAIR  = 16'h2000, TP_EX2IR = 16'h4000, TP_UPIR  = 16'h8000
  } cmr_tap_e;

endpackage : cmr_pkg

// *** logic/cmr_readback.sv ***
`timescale 1ns/1ps
module cmr_readback #(
  parameter bit LATER_GEN = 1'b1
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        CE,
  input  wire logic        CONFIG_CLOCK,
  input  wire logic        CHIP_SELECT_N,
  input  wire logic        DIRECTION_SELECT,
  input  wire logic [31:0] CFG_DATA_IN,
  output logic      [31:0] CFG_DATA_OUT,
  output logic             CFG_DATA_OE,
  output logic             READ_VALID,
  output logic             DONE,
  input  wire logic        TCK,
  input  wire logic        TMS,
  input  wire logic        TDI,
  output logic             TDO
);

  function automatic logic [31:0] rb_word(input logic [4:0] pad, input logic [15:0] frm,
                                          input logic [15:0] wrd, input logic [31:0] frame_address_reg,
                                          input logic en);
    logic [15:0] fa;
    fa = frame_address_reg[15:0] + frm - 16'h0001;
    if (pad != 5'h00 || frm == 16'h0000 || !en) begin
      rb_word = 32'h00000000;
    end else begin
      rb_word = {fa, wrd};
    end
  endfunction : rb_word

  function automatic cmr_pkg::cmr_tap_e tap_step(input cmr_pkg::cmr_tap_e s, input logic tms);
    case (s)
      cmr_pkg::TP_TLR:   tap_step = tms ? cmr_pkg::TP_TLR   : cmr_pkg::TP_RTI;
      cmr_pkg::TP_RTI:   tap_step = tms ? cmr_pkg::TP_SELDR : cmr_pkg::TP_RTI;
      cmr_pkg::TP_SELDR: tap_step = tms ? cmr_pkg::TP_SELIR : cmr_pkg::TP_CAPDR;
      cmr_pkg::TP_CAPDR: tap_step = tms ? cmr_pkg::TP_EX1DR : cmr_pkg::TP_SHDR;
      cmr_pkg::TP_SHDR:  tap_step = tms ? cmr_pkg::TP_EX1DR : cmr_pkg::TP_SHDR;
      cmr_pkg::TP_EX1DR: tap_step = tms ? cmr_pkg::TP_UPDR  : cmr_pkg::TP_PADR;
      cmr_pkg::TP_PADR:  tap_step = tms ? cmr_pkg::TP_EX2DR : cmr_pkg::TP_PADR;
      cmr_pkg::TP_EX2DR: tap_step = tms ? cmr_pkg::TP_UPDR  : cmr_pkg::TP_SHDR;
      cmr_pkg::TP_UPDR:  tap_step = tms ? cmr_pkg::TP_SELDR : cmr_pkg::TP_RTI;
      cmr_pkg::TP_SELIR: tap_step = tms ? cmr_pkg::TP_TLR   : cmr_pkg::TP_CAPIR;
      cmr_pkg::TP_CAPIR: tap_step = tms ? cmr_pkg::TP_EX1IR : cmr_pkg::TP_SHIR;
      cmr_pkg::TP_SHIR:  tap_step = tms ? cmr_pkg::TP_EX1IR : cmr_pkg::TP_SHIR;
      cmr_pkg::TP_EX1IR: tap_step = tms ? cmr_pkg::TP_UPIR  : cmr_pkg::TP_PAIR;
      cmr_pkg::TP_PAIR:  tap_step = tms ? cmr_pkg::TP_EX2IR : cmr_pkg::TP_PAIR;
      cmr_pkg::TP_EX2IR: tap_step = tms ? cmr_pkg::TP_UPIR  : cmr_pkg::TP_SHIR;
      cmr_pkg::TP_UPIR:  tap_step = tms ? cmr_pkg::TP_SELDR : cmr_pkg::TP_RTI;
      default:           tap_step = cmr_pkg::TP_TLR;
    endcase
  endfunction : tap_step

  // ==========================================================================
  // JTAG side, system clock; pins pass two flops first
  // ==========================================================================
  logic tck_m, tck_s, tck_q, tms_m, tms_s, tdi_m, tdi_s, oack_m, oack_s, oack_q;
  cmr_pkg::cmr_tap_e tap_reg, tap_next;
  logic [5:0]  ir_reg, ir_next, irs_reg, irs_next;
  logic [31:0] dr_reg, dr_next, jin_word_reg, jin_word_next, out_word_reg, out_word_next;
  logic [4:0]  bit_reg, bit_next;
  logic        jin_tgl_reg, jin_tgl_next, oreq_tgl_reg, oreq_tgl_next, tdo_reg, tdo_next;
  logic        rise;
  // Written only by the packet processor; read here once its toggle has crossed
  logic [31:0] xfer_reg;
  logic        oack_reg;

  assign rise = tck_s & ~tck_q;
  assign TDO  = tdo_reg;

  always_comb begin
    tap_next      = tap_reg;
    ir_next       = ir_reg;
    irs_next      = irs_reg;
    dr_next       = dr_reg;
    bit_next      = bit_reg;
    jin_word_next = jin_word_reg;
    jin_tgl_next  = jin_tgl_reg;
    oreq_tgl_next = oreq_tgl_reg;
    out_word_next = (oack_s != oack_q) ? xfer_reg : out_word_reg;
    if (rise) begin
      tap_next = tap_step(tap_reg, tms_s);
      case (tap_reg)
        cmr_pkg::TP_TLR:   ir_next = cmr_pkg::IR_RESET;
        cmr_pkg::TP_CAPIR: irs_next = cmr_pkg::IR_CAPTURE;
        cmr_pkg::TP_SHIR:  irs_next = {tdi_s, irs_reg[5:1]};
        cmr_pkg::TP_UPIR: begin
          ir_next = irs_reg;
          // Prefetch so the first capture already holds a readback word
          if (irs_reg == cmr_pkg::IR_CFG_OUT) oreq_tgl_next = ~oreq_tgl_reg;
        end
        cmr_pkg::TP_CAPDR: begin
          bit_next = 5'h00;
          if (ir_reg == cmr_pkg::IR_CFG_OUT) begin
            dr_next       = out_word_reg;
            oreq_tgl_next = ~oreq_tgl_reg;
          end
        end
        cmr_pkg::TP_SHDR: begin
          dr_next  = {dr_reg[30:0], tdi_s};
          bit_next = bit_reg + 5'h01;
          if (bit_reg == cmr_pkg::LAST_BIT && ir_reg == cmr_pkg::IR_CFG_IN) begin
            jin_word_next = {dr_reg[30:0], tdi_s};
            jin_tgl_next  = ~jin_tgl_reg;
          end
          if (bit_reg == cmr_pkg::LAST_BIT && ir_reg == cmr_pkg::IR_CFG_OUT) begin
            dr_next       = out_word_reg;
            oreq_tgl_next = ~oreq_tgl_reg;
          end
        end
        default: ;
      endcase
    end
    tdo_next = (tap_next == cmr_pkg::TP_SHIR) ? irs_next[0] : dr_next[31];
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      {tck_m, tck_s, tck_q, tms_m, tms_s, tdi_m, tdi_s} <= 7'h00;
      {oack_m, oack_s, oack_q}                         <= 3'h0;
      tap_reg      <= cmr_pkg::TP_TLR;
      ir_reg       <= cmr_pkg::IR_RESET;
      irs_reg      <= 6'h00;
      dr_reg       <= 32'h00000000;
      bit_reg      <= 5'h00;
      jin_word_reg <= 32'h00000000;
      jin_tgl_reg  <= 1'b0;
      oreq_tgl_reg <= 1'b0;
      out_word_reg <= 32'h00000000;
      tdo_reg      <= 1'b0;
    end else if (CE) begin
      {tck_m, tck_s, tck_q} <= {TCK, tck_m, tck_s};
      {tms_m, tms_s}        <= {TMS, tms_m};
      {tdi_m, tdi_s}        <= {TDI, tdi_m};
      {oack_m, oack_s, oack_q} <= {oack_reg, oack_m, oack_s};
      tap_reg      <= tap_next;
      ir_reg       <= ir_next;
      irs_reg      <= irs_next;
      dr_reg       <= dr_next;
      bit_reg      <= bit_next;
      jin_word_reg <= jin_word_next;
      jin_tgl_reg  <= jin_tgl_next;
      oreq_tgl_reg <= oreq_tgl_next;
      out_word_reg <= out_word_next;
      tdo_reg      <= tdo_next;
    end
  end

  // ==========================================================================
  // Packet processor, configuration clock domain
  // ==========================================================================
  logic rst_m, lrst, jt_m, jt_s, jt_q, oq_m, oq_s;
  cmr_pkg::cmr_link_e lst_reg, lst_next;
  cmr_pkg::cmr_hdr_s  hdr;
  logic [31:0] far_reg, far_next, dout_reg, dout_next, xfer_next, word, cur;
  logic [26:0] rem_reg, rem_next;
  logic [15:0] wrd_reg, wrd_next, frm_reg, frm_next;
  logic [10:0] wcnt_reg, wcnt_next;
  logic [7:0]  start_reg, start_next;
  logic [4:0]  pad_reg, pad_next, waddr_reg, waddr_next;
  logic [1:0]  lat_reg, lat_next;
  logic read_config_cmd_reg, read_config_cmd_next, done_reg, done_next, dir_q_reg, valid_reg, valid_next;
  logic oe_reg, oack_next, par_wr, jin_evt, w_valid, abort, par_pop, j_pop, pop;
  logic sd_cmd, start_rd;

  // A JTAG word landing in the same clock as a parallel word is dropped;
  // the two ports are not used together
  assign par_wr  = ~CHIP_SELECT_N & ~DIRECTION_SELECT;
  assign jin_evt = jt_s ^ jt_q;
  assign w_valid = par_wr | jin_evt;
  assign word    = par_wr ? CFG_DATA_IN : jin_word_reg;
  assign hdr     = cmr_pkg::cmr_hdr_s'(word);
  assign abort   = ~CHIP_SELECT_N & (DIRECTION_SELECT != dir_q_reg);
  assign par_pop = ~CHIP_SELECT_N & DIRECTION_SELECT & ~abort &
                   (lat_reg == cmr_pkg::READ_LATENCY) & (rem_reg != 27'h0);
  assign j_pop   = (oq_s != oack_reg) & ~par_pop;
  assign pop     = par_pop | (j_pop & (rem_reg != 27'h0));
  assign cur     = rb_word(pad_reg, frm_reg, wrd_reg, far_reg, read_config_cmd_reg);

  assign CFG_DATA_OUT = dout_reg;
  assign CFG_DATA_OE  = oe_reg;
  assign READ_VALID   = valid_reg;
  assign DONE         = done_reg;

  always_comb begin
    lst_next   = lst_reg;
    far_next   = far_reg;
    rem_next   = rem_reg;
    wcnt_next  = wcnt_reg;
    waddr_next = waddr_reg;
    read_config_cmd_next  = read_config_cmd_reg;
    done_next  = done_reg;
    start_next = start_reg;
    sd_cmd     = 1'b0;
    start_rd   = 1'b0;
    if (start_reg != 8'h00) begin
      start_next = start_reg - 8'h01;
      if (start_reg == 8'h01) done_next = 1'b1;
    end
    if (w_valid) begin
      case (lst_reg)
        cmr_pkg::LK_HUNT:  if (word == cmr_pkg::BUS_SYNC_WORD) lst_next = cmr_pkg::LK_WIDTH;
        cmr_pkg::LK_WIDTH: lst_next = (word == cmr_pkg::BUS_DETECT_WORD) ? cmr_pkg::LK_SYNC
                                                                        : cmr_pkg::LK_HUNT;
        cmr_pkg::LK_SYNC:  if (word == cmr_pkg::SYNC_WORD) lst_next = cmr_pkg::LK_HDR;
        cmr_pkg::LK_HDR: begin
          if (hdr.ptype == cmr_pkg::PKT_TYPE1 && hdr.op == cmr_pkg::OP_WRITE &&
              hdr.count != 11'h000) begin
            waddr_next = hdr.addr;
            wcnt_next  = hdr.count;
            lst_next   = cmr_pkg::LK_WDATA;
          end else if (hdr.ptype == cmr_pkg::PKT_TYPE1 && hdr.op == cmr_pkg::OP_READ &&
                       hdr.addr == cmr_pkg::ADDR_FRAME_DATA_OUT_REG) begin
            if (hdr.count == 11'h000) lst_next = cmr_pkg::LK_T2;
            else begin
              rem_next = {16'h0000, hdr.count};
              start_rd = 1'b1;
            end
          end
        end
        cmr_pkg::LK_T2: begin
          lst_next = cmr_pkg::LK_HDR;
          if (word[31:29] == cmr_pkg::PKT_TYPE2) begin
            rem_next = word[26:0];
            start_rd = 1'b1;
          end
        end
        cmr_pkg::LK_WDATA: begin
          wcnt_next = wcnt_reg - 11'h001;
          if (wcnt_reg == 11'h001) lst_next = cmr_pkg::LK_HDR;
          if (waddr_reg == cmr_pkg::ADDR_FRAME_ADDRESS_REG) far_next = word;
          if (waddr_reg == cmr_pkg::ADDR_COMMAND_REG) begin
            case (word[4:0])
              cmr_pkg::SHUTDOWN_CMD: begin
                sd_cmd     = 1'b1;
                done_next  = 1'b0;
                start_next = 8'h00;
              end
              cmr_pkg::START_CMD: begin
                start_next = cmr_pkg::STARTUP_CYCLES;
                read_config_cmd_next  = 1'b0;
              end
              cmr_pkg::READ_CONFIG_CMD:   read_config_cmd_next = 1'b1;
              cmr_pkg::DESYNCHRONIZE_CMD: lst_next  = cmr_pkg::LK_HUNT;
              default: ;
            endcase
          end
        end
        default: lst_next = cmr_pkg::LK_HUNT;
      endcase
    end
    if (!start_rd && pop) rem_next = rem_reg - 27'h1;
  end

  // Readback stream: pipeline pad, one dummy frame, then requested frames
  always_comb begin
    pad_next   = pad_reg;
    frm_next   = frm_reg;
    wrd_next   = wrd_reg;
    dout_next  = dout_reg;
    xfer_next  = xfer_reg;
    oack_next  = oack_reg;
    valid_next = par_pop;
    lat_next   = lat_reg;
    if (CHIP_SELECT_N || !DIRECTION_SELECT || abort) lat_next = 2'h0;
    else if (lat_reg != cmr_pkg::READ_LATENCY) lat_next = lat_reg + 2'h1;
    if (start_rd) begin
      pad_next = LATER_GEN ? cmr_pkg::PIPE_WORDS_LATER : cmr_pkg::PIPE_WORDS_EARLY;
      frm_next = 16'h0000;
      wrd_next = 16'h0000;
    end else if (pop) begin
      if (pad_reg != 5'h00) pad_next = pad_reg - 5'h01;
      else if (wrd_reg == cmr_pkg::WORDS_PER_FRAME - 16'h0001) begin
        wrd_next = 16'h0000;
        frm_next = frm_reg + 16'h0001;
      end else wrd_next = wrd_reg + 16'h0001;
    end
    if (par_pop) dout_next = cur;
    // JTAG waits while the parallel port is draining; words past the count read as zero
    if (j_pop) begin
      xfer_next = (rem_reg != 27'h0) ? cur : 32'h00000000;
      oack_next = ~oack_reg;
    end
  end

  always_ff @(posedge CONFIG_CLOCK) begin
    {rst_m, lrst} <= {RESET, rst_m};
    if (lrst) begin
      {jt_m, jt_s, jt_q, oq_m, oq_s} <= 5'h00;
      lst_reg   <= cmr_pkg::LK_HUNT;
      far_reg   <= 32'h00000000;
      rem_reg   <= 27'h0;
      wcnt_reg  <= 11'h000;
      waddr_reg <= 5'h00;
      read_config_cmd_reg  <= 1'b0;
      done_reg  <= 1'b1;
      start_reg <= 8'h00;
      pad_reg   <= 5'h00;
      frm_reg   <= 16'h0000;
      wrd_reg   <= 16'h0000;
      dout_reg  <= 32'h00000000;
      xfer_reg  <= 32'h00000000;
      oack_reg  <= 1'b0;
      valid_reg <= 1'b0;
      lat_reg   <= 2'h0;
      dir_q_reg <= 1'b0;
      oe_reg    <= 1'b0;
    end else begin
      {jt_m, jt_s, jt_q} <= {jin_tgl_reg, jt_m, jt_s};
      {oq_m, oq_s}       <= {oreq_tgl_reg, oq_m};
      lst_reg   <= lst_next;
      far_reg   <= far_next;
      rem_reg   <= rem_next;
      wcnt_reg  <= wcnt_next;
      waddr_reg <= waddr_next;
      read_config_cmd_reg  <= read_config_cmd_next;
      done_reg  <= done_next;
      start_reg <= start_next;
      pad_reg   <= pad_next;
      frm_reg   <= frm_next;
      wrd_reg   <= wrd_next;
      dout_reg  <= dout_next;
      xfer_reg  <= xfer_next;
      oack_reg  <= oack_next;
      valid_reg <= valid_next;
      lat_reg   <= lat_next;
      dir_q_reg <= DIRECTION_SELECT;
      oe_reg    <= ~CHIP_SELECT_N & DIRECTION_SELECT;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  done_low_a: assert property (@(posedge CONFIG_CLOCK) disable iff (lrst)
    sd_cmd |=> !DONE ##1 (!DONE || start_reg == 8'h00)) else $error("done not low after shutdown");
  read_latency_a: assert property (@(posedge CONFIG_CLOCK) disable iff (lrst)
    ($fell(CHIP_SELECT_N) && DIRECTION_SELECT && rem_reg > 27'h2 && !j_pop)
    ##1 (!CHIP_SELECT_N && DIRECTION_SELECT)[*2] |=> READ_VALID) else $error("read data late");
  read_count_a: assert property (@(posedge CONFIG_CLOCK) disable iff (lrst)
    (par_pop && rem_reg == 27'h1 && !start_rd) |=> rem_reg == 27'h0 ##1 !READ_VALID)
    else $error("read ran past count");
  dummy_frame_a: assert property (@(posedge CONFIG_CLOCK) disable iff (lrst)
    (par_pop && pad_reg == 5'h00 && frm_reg == 16'h0000) |=> CFG_DATA_OUT == 32'h00000000)
    else $error("dummy frame not zero");
  dir_out_a: assert property (@(posedge CONFIG_CLOCK) disable iff (lrst)
    !DIRECTION_SELECT |=> !CFG_DATA_OE && !READ_VALID) else $error("driving in write direction");
  jtag_word_a: assert property (@(posedge CLK) disable iff (RESET || !CE)
    (rise && tap_reg == cmr_pkg::TP_SHDR && ir_reg == cmr_pkg::IR_CFG_IN && bit_reg == 5'h1f)
    |=> jin_tgl_reg != $past(jin_tgl_reg) && jin_word_reg[0] == $past(tdi_s))
    else $error("jtag word not forwarded");
  msb_first_a: assert property (@(posedge CLK) disable iff (RESET || !CE)
    (rise && tap_reg == cmr_pkg::TP_SHDR && ir_reg == cmr_pkg::IR_CFG_IN && bit_reg == 5'h1f)
    |=> jin_word_reg[31:1] == $past(dr_reg[30:0])) else $error("word order wrong");
  ir_shift_a: assert property (@(posedge CLK) disable iff (RESET || !CE)
    (rise && tap_reg == cmr_pkg::TP_SHIR) |=> irs_reg[5] == $past(tdi_s))
    else $error("instruction not lsb first");
  cfg_out_a: assert property (@(posedge CLK) disable iff (RESET || !CE)
    (rise && tap_reg == cmr_pkg::TP_SHDR && ir_reg == cmr_pkg::IR_CFG_OUT && bit_reg != 5'h1f)
    |=> TDO == $past(dr_reg[30])) else $error("cfg-out bit not presented");
  read_seen_c: cover property (@(posedge CONFIG_CLOCK) disable iff (lrst) $rose(READ_VALID));
  done_back_c: cover property (@(posedge CONFIG_CLOCK) disable iff (lrst) $rose(DONE));
  desynchronize_cmd_c: cover property (@(posedge CONFIG_CLOCK) disable iff (lrst)
    lst_reg == cmr_pkg::LK_WDATA ##1 lst_reg == cmr_pkg::LK_HUNT);
  jtag_in_c: cover property (@(posedge CLK) disable iff (RESET) $changed(jin_tgl_reg));

endmodule : cmr_readback

// *** tb/cmr_host_model.sv ***
`timescale 1ns/1ps
module cmr_host_model (
  input  wire logic        config_clock,
  input  wire logic        rv,
  input  wire logic [31:0] dout,
  output logic             cs_n,
  output logic             dir,
  output logic      [31:0] din
);
  logic [31:0] w [0:255];
  initial begin
    cs_n = 1'b1;
    dir  = 1'b0;
    din  = 32'hffffffff;
  end
  // ==========================================================================
  // Bus cycles
  // ==========================================================================
  // Select stays low across back-to-back words
  task automatic wr(input logic [31:0] v);
    @(posedge config_clock);
    #1;
    cs_n = 1'b0;
    din  = v;
  endtask : wr
  // No pull on the data bus, so a released bus shows the inverse of the last word
  task automatic rel();
    @(posedge config_clock);
    #1;
    cs_n = 1'b1;
    din  = ~din;
  endtask : rel
  task automatic turn(input logic d);
    rel();
    @(posedge config_clock);
    #1;
    dir = d;
  endtask : turn
  // Counts edges from the first edge that samples select low
  task automatic rd(output int cnt, output int first);
    cnt   = 0;
    first = 0;
    turn(1'b1);
    @(posedge config_clock);
    #1;
    cs_n = 1'b0;
    for (int k = 1; k < 300; k++) begin
      @(posedge config_clock);
      #1;
      if (rv === 1'b1) begin
        if (cnt == 0) first = k;
        w[cnt[7:0]] = dout;
        cnt++;
      end
    end
    turn(1'b0);
  endtask : rd
endmodule : cmr_host_model

// *** tb/cmr_readback_test.sv ***
`timescale 1ns/1ps
module cmr_readback_test;
  logic        clk, reset, config_clock, cs_n, dir, rv, oe, done;
  logic        ce, tck, tms, tdi, tdo;
  logic [31:0] din, dout;
  int          fail_count, check_count, cnt, first, oe_cnt;
  cmr_readback #(.LATER_GEN(1'b1)) i_cmr_readback (.CLK(clk), .RESET(reset), .CE(ce),
    .CONFIG_CLOCK(config_clock), .CHIP_SELECT_N(cs_n), .DIRECTION_SELECT(dir), .CFG_DATA_IN(din),
    .CFG_DATA_OUT(dout), .CFG_DATA_OE(oe), .READ_VALID(rv), .DONE(done), .TCK(tck),
    .TMS(tms), .TDI(tdi), .TDO(tdo));
  cmr_host_model i_cmr_host_model (.config_clock(config_clock), .rv(rv), .dout(dout), .cs_n(cs_n), .dir(dir), .din(din));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cmd(input logic [31:0] c);
    i_cmr_host_model.wr(32'h30008001);
    i_cmr_host_model.wr(c);
    i_cmr_host_model.wr(32'h20000000);
  endtask : cmd
  // One TCK period is nine system clocks, well under the synchroniser's limit
  task automatic jt(input logic ms, input logic di);
    @(posedge clk);
    #1;
    tms = ms;
    tdi = di;
    repeat (4) @(posedge clk);
    #1;
    tck = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    tck = 1'b0;
  endtask : jt
  // Pin drive enable, looked at once settled after each link edge
  always @(posedge config_clock) begin
    #1;
    if (oe === 1'b1) oe_cnt++;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_shutdown();
    logic [31:0] op [6] = '{32'hffffffff, 32'h000000bb, 32'h11220044, 32'hffffffff, 32'haa995566, 32'h20000000};
    foreach (op[i]) i_cmr_host_model.wr(op[i]);
    i_cmr_host_model.rel();
    chk("done before shutdown", 32'h1, {31'h0, done});
    cmd(32'h0000000b);
    i_cmr_host_model.rel();
    chk("done in shutdown", 32'h0, {31'h0, done});
    cmd(32'h00000007);
    repeat (5) i_cmr_host_model.wr(32'h20000000);
    i_cmr_host_model.rel();
    chk("done after crc reset", 32'h0, {31'h0, done});
    $display("test shutdown finished");
  endtask : t_shutdown
  // One frame requested: 100 x 2 + 25 = 225 words
  task automatic t_read();
    cmd(32'h00000004);
    i_cmr_host_model.wr(32'h30002001);
    i_cmr_host_model.wr(32'h00000000);
    i_cmr_host_model.wr(32'h28006000);
    i_cmr_host_model.wr(32'h480000e1);
    repeat (64) i_cmr_host_model.wr(32'h20000000);
    i_cmr_host_model.rel();
    i_cmr_host_model.rd(cnt, first);
    chk("word count", 32'he1, cnt);
    chk("first valid edge", 32'h3, first);
    chk("enable edges", 32'h12c, oe_cnt);
    chk("pad word", 32'h0, i_cmr_host_model.w[10]);
    chk("dummy frame end", 32'h0, i_cmr_host_model.w[124]);
    chk("frame word 5", 32'h5, i_cmr_host_model.w[130]);
    chk("last word", 32'h63, i_cmr_host_model.w[224]);
    $display("test read finished");
  endtask : t_read
  task automatic t_restart();
    i_cmr_host_model.wr(32'h20000000);
    cmd(32'h00000005);
    i_cmr_host_model.rel();
    chk("done before startup", 32'h0, {31'h0, done});
    for (int k = 0; k < 40 && done !== 1'b1; k++) @(posedge config_clock);
    chk("done after start", 32'h1, {31'h0, done});
    cmd(32'h00000007);
    i_cmr_host_model.wr(32'h30008001);
    i_cmr_host_model.wr(32'h0000000d);
    repeat (2) i_cmr_host_model.wr(32'h20000000);
    i_cmr_host_model.rel();
    chk("done after desynchronize_cmd", 32'h1, {31'h0, done});
    $display("test restart finished");
  endtask : t_restart
  // Shutdown over cfg-in, then one cfg-out word with nothing left to read
  task automatic t_jtag();
    logic [31:0] op [9] = '{32'hffffffff, 32'h000000bb, 32'h11220044, 32'hffffffff, 32'haa995566,
                            32'h20000000, 32'h30008001, 32'h0000000b, 32'h20000000};
    logic        seen = 1'b0;
    repeat (5) jt(1'b1, 1'b0);
    jt(1'b0, 1'b0);
    repeat (2) jt(1'b1, 1'b0);
    repeat (2) jt(1'b0, 1'b0);
    chk("tdo capture", {31'h0, cmr_pkg::IR_CAPTURE[0]}, {31'h0, tdo});
    // A TCK pulse while the enable is low must be lost, not shifted
    ce = 1'b0;
    jt(1'b0, 1'b0);
    ce = 1'b1;
    chk("tdo frozen", {31'h0, cmr_pkg::IR_CAPTURE[0]}, {31'h0, tdo});
    for (int i = 0; i < 6; i++) jt(i == 5, cmr_pkg::IR_CFG_IN[i]);
    repeat (2) jt(1'b1, 1'b0);
    repeat (2) jt(1'b0, 1'b0);
    for (int w = 0; w < 9; w++) begin
      for (int b = 31; b >= 0; b--) jt(w == 8 && b == 0, op[w][b]);
    end
    repeat (3) jt(1'b1, 1'b0);
    repeat (2) jt(1'b0, 1'b0);
    for (int i = 0; i < 6; i++) jt(i == 5, cmr_pkg::IR_CFG_OUT[i]);
    repeat (2) jt(1'b1, 1'b0);
    repeat (2) jt(1'b0, 1'b0);
    for (int b = 31; b >= 0; b--) begin
      seen = seen | tdo;
      jt(b == 0, 1'b0);
    end
    repeat (5) jt(1'b1, 1'b0);
    chk("cfg-out past count", 32'h0, {31'h0, seen});
    chk("done after jtag shutdown", 32'h0, {31'h0, done});
    $display("test jtag finished");
  endtask : t_jtag
  // ==========================================================================
  // Clocks, reset and run
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    config_clock = 1'b0;
    #3;
    forever #6 config_clock = ~config_clock;
  end
  // Tests take about 31 us; the limit allows roughly three times that
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
  initial begin
    fail_count  = 0;
    check_count = 0;
    reset       = 1'b1;
    ce          = 1'b1;
    tck         = 1'b0;
    tms         = 1'b1;
    tdi         = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (6) @(posedge config_clock);
    t_shutdown();
    t_read();
    t_restart();
    t_jtag();
    stop_test();
  end
endmodule : cmr_readback_test
